// File: include/skss_pkg.sv
// Purpose: Constants for the servo kill switch and navigation light sequencer.
// Assumes: System clock of 250 MHz.
// Notes:   Times are kept in their own units and converted to 1 us ticks here; only the tick length is in cycles.
package skss_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned TICK_NS         = 1000;
  localparam int unsigned TICK_CYCLES     = TICK_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned ON_LIMIT_US     = 1550;
  localparam int unsigned OFF_LIMIT_US    = 1450;
  localparam int unsigned OFF_DELAY_MS    = 2000;
  localparam int unsigned OFF_DELAY_TICKS = OFF_DELAY_MS * 1000;
  localparam int unsigned FRAME_US        = 1_000_000;
  localparam int unsigned SLOT_COUNT      = 17;
  localparam int unsigned SLOT_TICKS      = FRAME_US / SLOT_COUNT;
  localparam int unsigned WIDTH_MAX_US    = 4095;
  localparam logic [4:0]  TAIL_FIRST      = 5'h00;
  localparam logic [4:0]  TAIL_LAST       = 5'h03;
  localparam logic [4:0]  WING_FIRST      = 5'h08;
  localparam logic [4:0]  WING_LAST       = 5'h09;
  localparam logic        IGNITION_RESET  = 1'b1;
  typedef enum logic [1:0] {
    SKSS_IDLE  = 2'b00,
    SKSS_HIGH  = 2'b01
  } skss_meas_t;
endpackage

// File: src/skss_width_meter.sv
// Purpose: Measures each servo pulse width in microseconds.
// Assumes: Input already synchronised; tick is a one-cycle 1 us enable.
// Notes:   Widths above the counter range saturate.
`timescale 1ns/1ps
module skss_width_meter
  import skss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstSyncN,
  input  wire logic        tick,
  input  wire logic        servoLevel,
  output logic [11:0]      servoPulseWidth,
  output logic             widthValid
);
  skss_meas_t  state, next_state;
  logic [11:0] count, next_count;
  logic [11:0] next_servoPulseWidth;
  logic        next_widthValid;

  always_comb begin
    next_state           = state;
    next_count           = count;
    next_servoPulseWidth = servoPulseWidth;
    next_widthValid      = 1'b0;
    case (state)
      SKSS_IDLE: begin
        if (servoLevel) begin
          next_state = SKSS_HIGH;
          next_count = 12'h000;
        end
      end
      SKSS_HIGH: begin
        if (!servoLevel) begin
          next_state           = SKSS_IDLE;
          next_servoPulseWidth = count;
          next_widthValid      = 1'b1;
        end else if (tick && count != 12'(WIDTH_MAX_US)) begin
          next_count = count + 12'h001;
        end
      end
      default: next_state = SKSS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state           <= SKSS_IDLE;
      count           <= 12'h000;
      servoPulseWidth <= 12'h000;
      widthValid      <= 1'b0;
    end else begin
      state           <= next_state;
      count           <= next_count;
      servoPulseWidth <= next_servoPulseWidth;
      widthValid      <= next_widthValid;
    end
  end
endmodule // skss_width_meter

// File: src/skss_top.sv
// Purpose: Servo-driven ignition kill switch with navigation light sequencing.
// Assumes: One 250 MHz clock; servo and polarity inputs come from pins.
// Notes:   Width is measured at 1 us resolution.
`timescale 1ns/1ps
module skss_top
  import skss_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic servoIn,
  input  wire logic polaritySelectShortN,
  output logic      ignitionEnable,
  output logic      posRedWing,
  output logic      posGreenWing,
  output logic      posWhiteTail,
  output logic      strobeRedTail,
  output logic      strobeWhiteLeft,
  output logic      strobeWhiteRight
);
  logic [1:0]  rstPipe;
  logic        rstSyncN;
  logic [2:0]  servoSync;
  logic [2:0]  polSync;
  logic        servoLevel;
  logic        next_servoLevel;
  logic        polShorted;
  logic        next_polShorted;
  logic [7:0]  tickCount;
  logic [7:0]  next_tickCount;
  logic        tick;
  logic [11:0] servoPulseWidth;
  logic        widthValid;
  logic [21:0] offTimer;
  logic [21:0] next_offTimer;
  logic        offPending;
  logic        next_offPending;
  logic        next_ignitionEnable;
  logic [15:0] slotTicks;
  logic [15:0] next_slotTicks;
  logic [4:0]  slot;
  logic [4:0]  next_slot;
  logic        widthHigh;
  logic        widthLow;
  logic        wantOn;
  logic        wantOff;
  logic        next_strobeRedTail;
  logic        next_strobeWhite;
  logic        next_pos;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // Pin inputs change only once the second and third stages agree.
  always_comb begin
    next_servoLevel = (servoSync[1] == servoSync[2]) ? servoSync[2] : servoLevel;
    next_polShorted = (polSync[1] == polSync[2]) ? !polSync[2] : polShorted;
  end

  // The jumper pin idles high when open, so its stages reset to ones and a
  // reset never looks like a freshly shorted jumper.
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      servoSync  <= 3'h0;
      polSync    <= 3'h7;
      servoLevel <= 1'b0;
      polShorted <= 1'b0;
    end else begin
      servoSync  <= {servoSync[1:0], servoIn};
      polSync    <= {polSync[1:0], polaritySelectShortN};
      servoLevel <= next_servoLevel;
      polShorted <= next_polShorted;
    end
  end

  always_comb begin
    next_tickCount = (tickCount == 8'(TICK_CYCLES - 1)) ? 8'h00 : tickCount + 8'h01;
  end
  assign tick = (tickCount == 8'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      tickCount <= 8'h00;
    end else begin
      tickCount <= next_tickCount;
    end
  end

  skss_width_meter u_meter (
    .clk             (clk),
    .rstSyncN        (rstSyncN),
    .tick            (tick),
    .servoLevel      (servoLevel),
    .servoPulseWidth (servoPulseWidth),
    .widthValid      (widthValid)
  );

  assign widthHigh = servoPulseWidth > 12'(ON_LIMIT_US);
  assign widthLow  = servoPulseWidth < 12'(OFF_LIMIT_US);
  assign wantOn  = widthValid && (polShorted ? widthLow : widthHigh);
  assign wantOff = widthValid && (polShorted ? widthHigh : widthLow);

  // Widths inside the dead band neither confirm nor cancel a pending off,
  // so the timer keeps running through jitter near the switch point.
  always_comb begin
    next_ignitionEnable = ignitionEnable;
    next_offPending     = offPending;
    next_offTimer       = offTimer;
    if (wantOn) begin
      next_ignitionEnable = 1'b1;
      next_offPending     = 1'b0;
      next_offTimer       = 22'h000000;
    end else if (wantOff && !offPending && ignitionEnable) begin
      next_offPending = 1'b1;
      next_offTimer   = 22'h000000;
    end else if (offPending && tick) begin
      if (offTimer == 22'(OFF_DELAY_TICKS - 1)) begin
        next_ignitionEnable = 1'b0;
        next_offPending     = 1'b0;
        next_offTimer       = 22'h000000;
      end else begin
        next_offTimer = offTimer + 22'h000001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ignitionEnable <= IGNITION_RESET;
      offPending     <= 1'b0;
      offTimer       <= 22'h000000;
    end else begin
      ignitionEnable <= next_ignitionEnable;
      offPending     <= next_offPending;
      offTimer       <= next_offTimer;
    end
  end

  always_comb begin
    next_slotTicks = slotTicks;
    next_slot      = slot;
    if (!ignitionEnable) begin
      next_slotTicks = 16'h0000;
      next_slot      = 5'h00;
    end else if (tick) begin
      if (slotTicks == 16'(SLOT_TICKS - 1)) begin
        next_slotTicks = 16'h0000;
        next_slot      = (slot == 5'(SLOT_COUNT - 1)) ? 5'h00 : slot + 5'h01;
      end else begin
        next_slotTicks = slotTicks + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      slotTicks <= 16'h0000;
      slot      <= 5'h00;
    end else begin
      slotTicks <= next_slotTicks;
      slot      <= next_slot;
    end
  end

  always_comb begin
    next_pos           = next_ignitionEnable;
    next_strobeRedTail = next_ignitionEnable && next_slot >= TAIL_FIRST
                         && next_slot <= TAIL_LAST;
    next_strobeWhite   = next_ignitionEnable && next_slot >= WING_FIRST
                         && next_slot <= WING_LAST;
  end

  // Lights register the same next values as the ignition, so a turn-off
  // darkens them on the very edge on which the ignition drops.
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      posRedWing       <= 1'b0;
      posGreenWing     <= 1'b0;
      posWhiteTail     <= 1'b0;
      strobeRedTail    <= 1'b0;
      strobeWhiteLeft  <= 1'b0;
      strobeWhiteRight <= 1'b0;
    end else begin
      posRedWing       <= next_pos;
      posGreenWing     <= next_pos;
      posWhiteTail     <= next_pos;
      strobeRedTail    <= next_strobeRedTail;
      strobeWhiteLeft  <= next_strobeWhite;
      strobeWhiteRight <= next_strobeWhite;
    end
  end
endmodule // skss_top

// File: sim/skss_checker.sv
// Purpose: Port assertions for the servo kill switch and light sequencer.
// Assumes: One clock domain; rstn is active low.
// Notes:   The 2 s turn-off is bounded here but too long to reach in simulation.
`timescale 1ns/1ps
module skss_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ignitionEnable,
  input wire logic posRedWing,
  input wire logic posGreenWing,
  input wire logic posWhiteTail,
  input wire logic strobeRedTail,
  input wire logic strobeWhiteLeft,
  input wire logic strobeWhiteRight
);
  logic [2:0]  rstCnt;
  logic [31:0] upCnt;
  wire anyLight = posRedWing | posGreenWing | posWhiteTail | strobeRedTail | strobeWhiteLeft;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstCnt <= 3'h0;
      upCnt  <= 32'h0;
    end else begin
      rstCnt <= (rstCnt == 3'h7) ? rstCnt : rstCnt + 3'h1;
      upCnt  <= (upCnt == 32'hFFFFFFFF) ? upCnt : upCnt + 32'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_lightsOff; !ignitionEnable |-> !anyLight; endproperty
  a_lightsOff: assert property (p_lightsOff) else $error("Light on while off");
  property p_resetOn; rstCnt < 3'h4 |-> ignitionEnable; endproperty
  a_resetOn: assert property (p_resetOn) else $error("Ignition off after reset");
  property p_posSteady; rstCnt >= 3'h4 && ignitionEnable |-> posRedWing; endproperty
  a_posSteady: assert property (p_posSteady) else $error("Position light dark");
  property p_posSame; posRedWing == posGreenWing && posRedWing == posWhiteTail; endproperty
  a_posSame: assert property (p_posSame) else $error("Position lights differ");
  property p_wingPair; strobeWhiteLeft == strobeWhiteRight; endproperty
  a_wingPair: assert property (p_wingPair) else $error("Wing strobes differ");
  property p_offDelay; $fell(ignitionEnable) |-> upCnt >= 32'h1DCD6500; endproperty
  a_offDelay: assert property (p_offDelay) else $error("Turn-off too early");
  property p_slotApart; !(strobeRedTail && strobeWhiteLeft); endproperty
  a_slotApart: assert property (p_slotApart) else $error("Strobes overlap");
  property p_frameStart; $rose(posRedWing) |-> strobeRedTail; endproperty
  a_frameStart: assert property (p_frameStart) else $error("Frame not at slot 0");
  property p_tailLong; $rose(strobeRedTail) |=> strobeRedTail [*8]; endproperty
  a_tailLong: assert property (p_tailLong) else $error("Tail strobe too short");
  property p_wingLong; $rose(strobeWhiteLeft) |=> strobeWhiteLeft [*8]; endproperty
  a_wingLong: assert property (p_wingLong) else $error("Wing strobe too short");
  c_lit: cover property ($rose(posRedWing));
  c_tail: cover property ($rose(strobeRedTail));
  c_off: cover property ($fell(ignitionEnable));
endmodule // skss_checker
bind skss_top skss_checker chk (.clk(clk), .rstn(rstn), .ignitionEnable(ignitionEnable),
  .posRedWing(posRedWing), .posGreenWing(posGreenWing), .posWhiteTail(posWhiteTail),
  .strobeRedTail(strobeRedTail), .strobeWhiteLeft(strobeWhiteLeft),
  .strobeWhiteRight(strobeWhiteRight));

// File: sim/skss_rx_model.sv
// Purpose: Receiver servo channel model.
// Assumes: Line idles low between pulses.
// Notes:   Width is given in microseconds.
`timescale 1ns/1ps
module skss_rx_model
  import skss_pkg::*;
(
  input  wire logic clk,
  output logic      servoOut
);
  initial servoOut = 1'b0;
  task automatic pulse(input int us);
    @(posedge clk) #1 servoOut = 1'b1;
    repeat (us * TICK_CYCLES) @(posedge clk);
    #1 servoOut = 1'b0;
  endtask
endmodule // skss_rx_model

// File: sim/test_servo_kill_switch_strobe.sv
// Purpose: Self-checking bench for the kill switch and light sequencer.
// Assumes: 250 MHz clock; short pulses only, since 2 s would not fit the run.
// Notes:   The completed turn-off is left to the checker bound.
`timescale 1ns/1ps
module test_servo_kill_switch_strobe;
  logic clk, rstn, servoIn, polSel;
  logic ign, pRed, pGreen, pTail, sTail, sLeft, sRight;
  int   n_fail = 0;
  int   checked = 0;
  skss_top uut (.clk(clk), .rstn(rstn), .servoIn(servoIn), .polaritySelectShortN(polSel),
    .ignitionEnable(ign), .posRedWing(pRed), .posGreenWing(pGreen), .posWhiteTail(pTail),
    .strobeRedTail(sTail), .strobeWhiteLeft(sLeft), .strobeWhiteRight(sRight));
  skss_rx_model rx (.clk(clk), .servoOut(servoIn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check_all(input logic on, input logic tail);
    chk(ign, 1'b1, "ignition");
    chk(pRed, on, "red position");
    chk(pGreen, on, "green position");
    chk(pTail, on, "tail position");
    chk(sTail, tail, "tail strobe");
    chk(sLeft, 1'b0, "left strobe");
    chk(sRight, 1'b0, "right strobe");
  endtask
  task test_reset;
    repeat (8) @(posedge clk);
    #1 check_all(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge clk);
    #1 check_all(1'b1, 1'b1);
    $display("test_reset done");
  endtask
  // An off request must wait; short pulses keep all but the wing strobes lit.
  task test_pulse(input logic polarity_select, input int us, input logic pend);
    @(posedge clk) #1 polSel = polarity_select;
    repeat (10) @(posedge clk);
    rx.pulse(us);
    repeat (20) @(posedge clk);
    #1 check_all(1'b1, 1'b1);
    chk(uut.offPending, pend, "off pending");
    $display("test_pulse pol %0b width %0d done", polarity_select, us);
  endtask
  task test_idle;
    repeat (2000) @(posedge clk);
    #1 check_all(1'b1, 1'b1);
    chk(uut.offPending, 1'b1, "pending held");
    $display("test_idle done");
  endtask
  initial begin
    rstn = 1'b0;
    polSel = 1'b1;
    test_reset;
    test_pulse(1'b1, 100, 1'b1);
    test_pulse(1'b0, 100, 1'b0);
    test_pulse(1'b1, 90, 1'b1);
    test_idle;
    print_verdict;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // test_servo_kill_switch_strobe
